// [design/csmc_defs.svh]
// register indices, field positions, reset values and timing counts
// assumes a 32-bit APB bus; byte address of a register is its index * 4
`ifndef CSMC_DEFS_SVH
`define CSMC_DEFS_SVH
`define CSMC_AW          14
`define CSMC_IDX_LOOP_LO 12'h010
`define CSMC_IDX_LOOP_HI 12'h01E
`define CSMC_IDX_PWR     12'h010
`define CSMC_IDX_CAL     12'h018
`define CSMC_IDX_REFEN   12'h01C
`define CSMC_IDX_DIV     12'h1E0
`define CSMC_IDX_ROUTE   12'h1E1
`define CSMC_IDX_UPD     12'h232
`define CSMC_IDX_NVCTL   12'h240
`define CSMC_IDX_STAT    12'h241
`define CSMC_SLOT_PWR    4'h0
`define CSMC_SLOT_CAL    4'h8
`define CSMC_SLOT_REFEN  4'hC
`define CSMC_POL_BIT     7
`define CSMC_CAL_BIT     0
`define CSMC_SRC_BIT     1
`define CSMC_BYP_BIT     0
`define CSMC_UPD_BIT     0
`define CSMC_SAVE_BIT    0
`define CSMC_PWR_NORMAL  2'h0
`define CSMC_PWR_DOWN    2'h1
`define CSMC_PWR_RST     8'h01
`define CSMC_DIV_RST     8'h00
`define CSMC_ROUTE_RST   8'h00
`define CSMC_CAL_TIME_NS 1000
`define CSMC_CLK_NS      8
`define CSMC_CAL_CYCLES  ((`CSMC_CAL_TIME_NS + `CSMC_CLK_NS - 1) / `CSMC_CLK_NS)
`endif

// [design/csmc_pkg.sv]
// types shared by the clock source configuration block
// assumes csmc_defs.svh for all numeric constants
package csmc_pkg;
  // one configuration image: loop bytes loop_power_and_polarity..0x01E, divider, routing
  typedef struct packed {
    logic [14:0][7:0] loop;
    logic [7:0]       div;
    logic [7:0]       route;
  } csmc_cfg_t;

  typedef enum logic [1:0] {
    CSMC_RESTORE = 2'b00,
    CSMC_IDLE    = 2'b01,
    CSMC_CAL     = 2'b10
  } csmc_state_t;
endpackage

// [design/csmc_top.sv]
// clock source and mode configuration: APB registers, staged update,
// oscillator calibration sequencer, nonvolatile save and restore
// assumes an EEPROM controller on pclk that answers nv_rd_req
// Functional notes
// RULE1 - per-function bits; save/restore image to storage
// RULE2 - loop power 00b runs loop normally
// RULE3 - source bit 1b selects internal oscillator
// RULE4 - bypass bit 0b uses post-divider ratio
// RULE5 - reference inputs follow three-bit enable field
// RULE6 - cal bit then update strobe starts calibration
// RULE7 - host clears cal bit before recalibrating
// RULE8 - host calibrates whenever oscillator used
// RULE9 - loop registers loop_power_and_polarity..0x01E hold loop settings
// RULE10 - host normally keeps divider with oscillator
// RULE11 - host keeps bypassed source below limit
// RULE12 - low-frequency mode differs only by bypass
// RULE13 - loop power 01b powers loop down
// RULE14 - source bit 0b selects external clock
// RULE15 - bypass bit 1b skips the post-divider
// RULE16 - reset: loop off, ratio 000b, external, divided
// RULE17 - writes staged; update bit commits, self-clears
`timescale 1ns/1ns
`include "csmc_defs.svh"
module csmc_top
  import csmc_pkg::*;
#(
  parameter int CAL_N = `CSMC_CAL_CYCLES
) (
  // apb slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [`CSMC_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // nonvolatile image store
  input  wire csmc_cfg_t         nv_rdata,
  input  wire logic              nv_valid,
  input  wire logic              nv_none,
  output logic                   nv_rd_req,
  output logic                   nv_wr,
  output csmc_cfg_t              nv_wdata,
  // active configuration toward the analog section
  output csmc_cfg_t              act_cfg,
  output logic                   pll_normal,
  output logic                   pll_pwrdn,
  output logic                   src_osc,
  output logic                   div_used,
  output logic [2:0]             div_ratio,
  output logic [2:0]             ref_en,
  output logic                   phase_frequency_comparator_neg,
  output logic                   cal_busy
);
  localparam int CAL_LAST = CAL_N - 1;

  csmc_cfg_t   stg, next_stg, next_act, next_nv_wdata;
  csmc_state_t state, next_state;
  logic [15:0] cnt, next_cnt;
  logic        cal_done, next_cal_done, restored, next_restored;
  logic        next_nv_wr, next_nv_rd_req, next_cal_busy;
  logic        next_pll_normal, next_pll_pwrdn, next_src_osc, next_div_used;
  logic [2:0]  next_div_ratio, next_ref_en;
  logic        next_pol;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr;
  logic [11:0] idx;
  logic        is_loop, is_div, is_route, is_upd, is_nvctl, is_stat, hit;
  logic        setup, wr, upd, start;

  // address decode, shared by both groups
  assign idx      = paddr[`CSMC_AW-1:2];
  assign is_loop  = (idx >= `CSMC_IDX_LOOP_LO) && (idx <= `CSMC_IDX_LOOP_HI);
  assign is_div   = (idx == `CSMC_IDX_DIV);
  assign is_route = (idx == `CSMC_IDX_ROUTE);
  assign is_upd   = (idx == `CSMC_IDX_UPD);
  assign is_nvctl = (idx == `CSMC_IDX_NVCTL);
  assign is_stat  = (idx == `CSMC_IDX_STAT);
  assign hit      = is_loop | is_div | is_route | is_upd | is_nvctl | is_stat;
  assign setup    = psel & ~penable;
  // only byte lane 0 carries data; other lanes hold nothing
  assign wr       = psel & penable & pready & pwrite & pstrb[0];
  assign upd      = wr & is_upd & pwdata[`CSMC_UPD_BIT];

  // staging, active image, calibration sequencer, save and restore
  always_comb begin
    next_stg      = stg;
    next_act      = act_cfg;
    next_state    = state;
    next_cnt      = cnt;
    next_cal_done = cal_done;
    next_restored = restored;
    next_nv_wr    = 1'b0;
    next_nv_wdata = nv_wdata;
    // writes only touch the staging copy
    if (wr && is_loop) next_stg.loop[idx[3:0]] = pwdata[7:0];  // RULE9
    if (wr && is_div) next_stg.div = pwdata[7:0];  // RULE1
    if (wr && is_route) next_stg.route = pwdata[7:0];  // RULE1
    case (state)
      CSMC_RESTORE: begin
        // stored image replaces the reset defaults without host action
        if (nv_valid) begin
          next_stg      = nv_rdata;  // RULE1
          next_act      = nv_rdata;  // RULE1
          next_restored = 1'b1;
          next_state    = CSMC_IDLE;
        end else if (nv_none) begin
          next_state = CSMC_IDLE;
        end
      end
      CSMC_IDLE, CSMC_CAL: begin
        if (upd) next_act = stg;  // RULE17
      end
      default: next_state = CSMC_IDLE;
    endcase
    // clear of the done flag first, so completion in the same cycle wins
    if (!next_act.loop[`CSMC_SLOT_CAL][`CSMC_CAL_BIT]) next_cal_done = 1'b0;
    // only a 0->1 edge of the active bit starts a run; a held 1 does not
    start = next_act.loop[`CSMC_SLOT_CAL][`CSMC_CAL_BIT] &
            ~act_cfg.loop[`CSMC_SLOT_CAL][`CSMC_CAL_BIT];  // RULE6 RULE7
    if (start) begin
      next_state    = CSMC_CAL;  // RULE6
      next_cnt      = 16'(CAL_LAST);
      next_cal_done = 1'b0;
    end else if (state == CSMC_CAL) begin
      if (cnt == 16'h0000) begin
        next_state    = CSMC_IDLE;
        next_cal_done = 1'b1;
      end else begin
        next_cnt = cnt - 16'h0001;
      end
    end
    // save snapshots the active image, never a half-staged one
    if (wr && is_nvctl && pwdata[`CSMC_SAVE_BIT] &&
        state != CSMC_RESTORE) begin
      next_nv_wr    = 1'b1;  // RULE1
      next_nv_wdata = act_cfg;
    end
    next_nv_rd_req  = (next_state == CSMC_RESTORE);
    next_cal_busy   = (next_state == CSMC_CAL);
    next_pll_normal =
      (next_act.loop[`CSMC_SLOT_PWR][1:0] == `CSMC_PWR_NORMAL);  // RULE2
    next_pll_pwrdn  =
      (next_act.loop[`CSMC_SLOT_PWR][1:0] == `CSMC_PWR_DOWN);  // RULE13
    next_pol        = next_act.loop[`CSMC_SLOT_PWR][`CSMC_POL_BIT];
    next_src_osc    = next_act.route[`CSMC_SRC_BIT];  // RULE3 RULE14
    // bypass changes nothing but the divider tap
    next_div_used   = ~next_act.route[`CSMC_BYP_BIT];  // RULE4 RULE15 RULE12
    next_div_ratio  = next_act.div[2:0];  // RULE4
    next_ref_en     = next_act.loop[`CSMC_SLOT_REFEN][2:0];  // RULE5
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stg        <= '{loop: {{14{8'h00}}, `CSMC_PWR_RST},
                      div: `CSMC_DIV_RST, route: `CSMC_ROUTE_RST};  // RULE16
      act_cfg    <= '{loop: {{14{8'h00}}, `CSMC_PWR_RST},
                      div: `CSMC_DIV_RST, route: `CSMC_ROUTE_RST};  // RULE16
      state      <= CSMC_RESTORE;
      cnt        <= 16'h0000;
      cal_done   <= 1'b0;
      restored   <= 1'b0;
      nv_wr      <= 1'b0;
      nv_wdata   <= '0;
      nv_rd_req  <= 1'b1;
      cal_busy   <= 1'b0;
      pll_normal <= 1'b0;
      pll_pwrdn  <= 1'b1;  // RULE16
      phase_frequency_comparator_neg <= 1'b0;
      src_osc    <= 1'b0;
      div_used   <= 1'b1;
      div_ratio  <= 3'h0;
      ref_en     <= 3'h0;
    end else begin
      stg        <= next_stg;
      act_cfg    <= next_act;
      state      <= next_state;
      cnt        <= next_cnt;
      cal_done   <= next_cal_done;
      restored   <= next_restored;
      nv_wr      <= next_nv_wr;
      nv_wdata   <= next_nv_wdata;
      nv_rd_req  <= next_nv_rd_req;
      cal_busy   <= next_cal_busy;
      pll_normal <= next_pll_normal;
      pll_pwrdn  <= next_pll_pwrdn;
      phase_frequency_comparator_neg <= next_pol;
      src_osc    <= next_src_osc;
      div_used   <= next_div_used;
      div_ratio  <= next_div_ratio;
      ref_en     <= next_ref_en;
    end
  end

  // apb answer: data captured in setup, so access never waits
  always_comb begin
    next_pready  = setup;
    next_pslverr = setup & ~hit;
    next_prdata  = 32'h0000_0000;
    if (setup && !pwrite) begin
      if (is_loop) next_prdata[7:0] = stg.loop[idx[3:0]];
      else if (is_div) next_prdata[7:0] = stg.div;
      else if (is_route) next_prdata[7:0] = stg.route;
      else if (is_stat) next_prdata[2:0] = {restored, cal_done, cal_busy};
      else next_prdata = 32'h0000_0000;  // update and save read as zero
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // commit that turns the active calibration bit on
  sequence s_cal_req;
    upd && stg.loop[`CSMC_SLOT_CAL][`CSMC_CAL_BIT] &&
    !act_cfg.loop[`CSMC_SLOT_CAL][`CSMC_CAL_BIT] && state != CSMC_RESTORE;
  endsequence

  // busy for exactly CAL_N samples, then idle
  sequence s_cal_run;
    (cal_busy throughout (##[CAL_LAST:CAL_LAST] 1'b1)) ##1 !cal_busy;
  endsequence

  chk_update_commit: assert property ( // RULE17
    upd && state != CSMC_RESTORE |=> act_cfg == $past(stg))
    else $error("update did not commit staging copy");
  chk_stage_holds: assert property ( // RULE17
    wr && is_div && state != CSMC_RESTORE && !start |=> $stable(act_cfg))
    else $error("staged write reached active image");
  chk_loop_power: assert property ( // RULE2
    pll_normal == (act_cfg.loop[`CSMC_SLOT_PWR][1:0] == `CSMC_PWR_NORMAL))
    else $error("loop power normal mismatch");
  chk_loop_down: assert property ( // RULE13
    pll_pwrdn == (act_cfg.loop[`CSMC_SLOT_PWR][1:0] == `CSMC_PWR_DOWN))
    else $error("loop power down mismatch");
  chk_source_route: assert property ( // RULE3
    src_osc == act_cfg.route[`CSMC_SRC_BIT])
    else $error("source select mismatch");
  chk_div_route: assert property ( // RULE15
    div_used != act_cfg.route[`CSMC_BYP_BIT] &&
    div_ratio == act_cfg.div[2:0])
    else $error("divider routing mismatch");
  chk_ref_enable: assert property ( // RULE5
    ref_en == act_cfg.loop[`CSMC_SLOT_REFEN][2:0])
    else $error("reference enable mismatch");
  // a start reloads the counter even if a run is still going
  chk_cal_start: assert property ( // RULE6
    s_cal_req |=> cal_busy && cnt == 16'(CAL_LAST))
    else $error("calibration did not start");
  chk_cal_length: assert property ( // RULE6
    $rose(cal_busy) |-> s_cal_run)
    else $error("calibration length wrong");
  chk_restore_load: assert property ( // RULE1
    state == CSMC_RESTORE && nv_valid |=> act_cfg == $past(nv_rdata))
    else $error("restored image not loaded");
  chk_reset_default: assert property ( // RULE16
    state == CSMC_RESTORE |-> pll_pwrdn && !src_osc && div_used &&
    div_ratio == 3'h0)
    else $error("reset defaults wrong");

  // register bus answers in the cycle after setup, error for holes
  chk_apb_answer: assert property ( // RULE1
    setup |=> pready && pslverr == !$past(hit))
    else $error("register bus answer wrong");

  // done stays up after a run until the active bit is cleared
  chk_cal_done_set: assert property ( // RULE6
    $fell(cal_busy) |-> cal_done)
    else $error("calibration done not set");
  chk_cal_done_clear: assert property ( // RULE7
    !act_cfg.loop[`CSMC_SLOT_CAL][`CSMC_CAL_BIT] && !cal_busy &&
    !$fell(cal_busy) |-> !cal_done)
    else $error("calibration done not cleared");

  // save takes the active image, one pulse per request
  chk_save_image: assert property ( // RULE1
    wr && is_nvctl && pwdata[`CSMC_SAVE_BIT] && state != CSMC_RESTORE
    |=> nv_wr && nv_wdata == $past(act_cfg))
    else $error("save image wrong");
  chk_save_pulse: assert property ( // RULE1
    nv_wr |=> !nv_wr)
    else $error("save pulse too long");

  // restore ends on either answer from the store
  chk_restore_end: assert property ( // RULE1
    state == CSMC_RESTORE && (nv_valid || nv_none) |=> !nv_rd_req)
    else $error("restore request held");
endmodule // csmc_top

// [verif/csmc_nv_model.sv]
// image store model on the far side of the nonvolatile port
// assumes pclk domain; the stored image survives presetn like storage
`timescale 1ns/1ns
module csmc_nv_model
  import csmc_pkg::*;
#(
  parameter int DELAY = 3
) (
  // clock and reset
  input  wire logic      pclk,
  input  wire logic      presetn,
  // image port
  input  wire logic      nv_rd_req,
  input  wire logic      nv_wr,
  input  wire csmc_cfg_t nv_wdata,
  output csmc_cfg_t      nv_rdata,
  output logic           nv_valid = 1'b0,
  output logic           nv_none = 1'b0
);
  csmc_cfg_t img = '0;
  logic      have = 1'b0;
  int        cnt = 0;

  // capture on save; not reset, so a later restore finds it
  always @(posedge pclk) begin
    if (nv_wr === 1'b1) begin
      img <= nv_wdata;
      have <= 1'b1;
    end
  end

  // slow answer to a restore request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      nv_valid <= 1'b0;
      nv_none <= 1'b0;
    end else if (nv_rd_req === 1'b1 && cnt < DELAY) begin
      cnt <= cnt + 1;
    end else if (nv_rd_req === 1'b1) begin
      nv_valid <= have;
      nv_none <= !have;
    end else begin
      cnt <= 0;
      nv_valid <= 1'b0;
      nv_none <= 1'b0;
    end
  end

  // data not offered shows garbage, not the last image
  assign nv_rdata = nv_valid ? img : ~img;
endmodule // csmc_nv_model

// [verif/csmc_top_tb.sv]
// self-checking bench for the clock source configuration block
// assumes csmc_nv_model as image store and CAL_N shortened to 4
`timescale 1ns/1ns
`include "csmc_defs.svh"
module csmc_top_tb
  import csmc_pkg::*;
;
  localparam int CAL_N = 4;
  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [`CSMC_AW-1:0] paddr = '0;
  logic [31:0]         pwdata = '0;
  logic [3:0]          pstrb = 4'hF;
  logic [31:0]         prdata, rdv;
  logic                pready, pslverr, erv, nv_valid, nv_none;
  logic                nv_rd_req, nv_wr, cal_busy;
  csmc_cfg_t           nv_rdata, nv_wdata, act_cfg;
  logic                pll_normal, pll_pwrdn, src_osc, div_used;
  logic                phase_frequency_comparator_neg;
  logic [2:0]          div_ratio, ref_en;
  int                  n_fail = 0;
  int                  cmp_count = 0;

  csmc_top #(.CAL_N(CAL_N)) dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .nv_rdata, .nv_valid, .nv_none, .nv_rd_req, .nv_wr, .nv_wdata,
    .act_cfg, .pll_normal, .pll_pwrdn, .src_osc, .div_used, .div_ratio,
    .ref_en, .phase_frequency_comparator_neg, .cal_busy);
  csmc_nv_model nv (.pclk, .presetn, .nv_rd_req, .nv_wr, .nv_wdata,
    .nv_rdata, .nv_valid, .nv_none);

  initial begin
    forever #4 pclk = ~pclk;
  end

  task automatic chk(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] idx,
                     input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle limit here; a hang is ended by the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk); // outputs settled before any check
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd(input logic [11:0] idx);
    apb(1'b0, idx, 8'h00);
  endtask

  task automatic do_reset;
    int n;
    // assert on a rising edge so a pending save pulse is taken first
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (nv_rd_req !== 1'b0 && n < 20);
    chk("restore done", nv_rd_req, 1'b0);
  endtask

  task automatic t_defaults;
    chk("pll_pwrdn", pll_pwrdn, 1'b1);
    chk("pll_normal", pll_normal, 1'b0);
    chk("src_osc", src_osc, 1'b0);
    chk("div_used", div_used, 1'b1);
    chk("div_ratio", div_ratio, 3'h0);
    $display("test defaults done");
  endtask

  task automatic t_stage;
    wr(`CSMC_IDX_PWR, 8'h80);
    wr(`CSMC_IDX_REFEN, 8'h05);
    wr(`CSMC_IDX_DIV, 8'h05);
    chk("staged pwrdn", pll_pwrdn, 1'b1);
    rd(`CSMC_IDX_REFEN);
    chk("staged readback", rdv, 32'h00000005);
    wr(`CSMC_IDX_UPD, 8'h01);
    chk("pll_normal", pll_normal, 1'b1);
    chk("ref_en", ref_en, 3'h5);
    chk("div_ratio", div_ratio, 3'h5);
    chk("polarity", phase_frequency_comparator_neg, 1'b1);
    rd(`CSMC_IDX_UPD);
    chk("update clears", rdv, 32'h00000000);
    // bench source taken as below the channel limit, so bypass is legal
    for (int i = 0; i < 4; i++) begin
      wr(`CSMC_IDX_ROUTE, 8'(i));
      wr(`CSMC_IDX_UPD, 8'h01);
      chk("src_osc", src_osc, i[1]);
      chk("div_used", div_used, !i[0]);
      chk("ratio kept", div_ratio, 3'h5);
    end
    wr(`CSMC_IDX_PWR, 8'h01);
    wr(`CSMC_IDX_UPD, 8'h01);
    chk("pll_pwrdn", pll_pwrdn, 1'b1);
    chk("pll off", pll_normal, 1'b0);
    rd(12'h100);
    chk("unmapped", erv, 1'b1);
    $display("test staging and routing done");
  endtask

  task automatic t_cal;
    wr(`CSMC_IDX_CAL, 8'h01);
    wr(`CSMC_IDX_UPD, 8'h01);
    chk("cal starts", cal_busy, 1'b1);
    repeat (CAL_N - 1) @(negedge pclk);
    chk("cal running", cal_busy, 1'b1);
    @(negedge pclk);
    chk("cal ends", cal_busy, 1'b0);
    rd(`CSMC_IDX_STAT);
    chk("cal done", rdv[1:0], 2'h2);
    wr(`CSMC_IDX_UPD, 8'h01);
    chk("held bit idle", cal_busy, 1'b0);
    wr(`CSMC_IDX_CAL, 8'h00);
    wr(`CSMC_IDX_UPD, 8'h01);
    rd(`CSMC_IDX_STAT);
    chk("cal cleared", rdv[1:0], 2'h0);
    wr(`CSMC_IDX_CAL, 8'h01);
    wr(`CSMC_IDX_UPD, 8'h01);
    chk("cal restarts", cal_busy, 1'b1);
    repeat (CAL_N + 2) @(negedge pclk);
    $display("test calibration done");
  endtask

  task automatic t_save;
    wr(`CSMC_IDX_NVCTL, 8'h01);
    chk("save pulse", nv_wr, 1'b1);
    chk("save route", nv_wdata.route, 32'h00000003);
    do_reset;
    chk("restored route", act_cfg.route, 32'h00000003);
    chk("restored src", src_osc, 1'b1);
    chk("restored pwrdn", pll_pwrdn, 1'b1);
    $display("test save and restore done");
  endtask

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog: whole run needs well under 2000 cycles
  initial begin
    #100000;
    n_fail++;
    end_of_test();
  end

  initial begin
    do_reset;
    t_defaults;
    t_stage;
    t_cal;
    t_save;
    end_of_test();
  end
endmodule // csmc_top_tb
